// file: core/dword_alu_pkg.sv
`default_nettype none
package dword_alu_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned DATA_W  = 64;
  localparam int unsigned SHAMT_W = 6;
  localparam int unsigned AMOUNT_W = 5;
  localparam int unsigned FUNCT_W = 6;
  localparam int unsigned REG_W   = 5;
  localparam int unsigned SIGN_BIT = 63;

  // ****************************************************************
  // Function-field encodings of the special opcode group
  // ****************************************************************
  localparam logic [5:0] FN_LOGIC_RIGHT_VAR    = 6'h16;
  localparam logic [5:0] FN_ARITH_RIGHT_VAR    = 6'h17;
  localparam logic [5:0] FN_SUB_TRAP           = 6'h2e;
  localparam logic [5:0] FN_SUB_WRAP           = 6'h2f;
  localparam logic [5:0] FN_LOGIC_RIGHT_FIXED  = 6'h3a;
  localparam logic [5:0] FN_ARITH_RIGHT_FIXED  = 6'h3b;
  localparam logic [5:0] FN_LOGIC_RIGHT_PLUS32 = 6'h3e;
  localparam logic [5:0] FN_ARITH_RIGHT_PLUS32 = 6'h3f;

  localparam logic [63:0] DATA_RST = 64'h0;
  localparam logic [4:0]  REG_RST  = 5'h0;

  typedef enum {
    op_none,
    dword_arith_right_fixed,
    dword_arith_right_plus32,
    dword_arith_right_variable,
    dword_logic_right_fixed,
    dword_logic_right_plus32,
    dword_logic_right_variable,
    dword_subtract_trapping,
    dword_subtract_wrapping
  } alu_op_t;

  // Issue bundle from decode
  typedef struct packed {
    logic        valid;
    logic [5:0]  funct;
    logic [4:0]  shift_amount_field;
    logic [4:0]  dest;
    logic [63:0] first_source_register;
    logic [63:0] second_operand_register;
  } issue_t;

  // Write-back bundle to the register file
  typedef struct packed {
    logic        wr_en;
    logic [4:0]  dest;
    logic [63:0] data;
  } wb_t;

endpackage
`default_nettype wire

// file: core/dword_right_shifter.sv
`default_nettype none
module dword_right_shifter (
  input  wire logic [63:0] value,
  input  wire logic [5:0]  count,
  input  wire logic        arith,
  output logic      [63:0] result
);
  import dword_alu_pkg::*;

  logic [63:0] fill;

  // ****************************************************************
  // Shift core
  // ****************************************************************
  always_comb begin
    fill   = {DATA_W{arith & value[SIGN_BIT]}};
    // Fill mask marks the vacated upper bits
    result = (value >> count) | ~({DATA_W{1'b1}} >> count) & fill;
  end

endmodule
`default_nettype wire

// file: core/doubleword_shift_subtract_alu.sv
`default_nettype none
module doubleword_shift_subtract_alu (
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  input  wire dword_alu_pkg::issue_t issue,
  output var  dword_alu_pkg::wb_t    wb,
  output logic                      unknown_op,
  output logic                      overflow_exc
);
  import dword_alu_pkg::*;

  alu_op_t     op;
  logic [5:0]  count;
  logic        arith;
  logic [63:0] shifted;
  logic [63:0] diff;
  logic        ovf;
  logic        is_shift;
  wb_t         wb_reg;
  wb_t         wb_next;
  logic        exc_reg;
  logic        exc_next;
  logic        bad_reg;

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic alu_op_t decode(input logic [5:0] fn);
    case (fn)
      FN_ARITH_RIGHT_FIXED:  decode = dword_arith_right_fixed;
      FN_ARITH_RIGHT_PLUS32: decode = dword_arith_right_plus32;
      FN_ARITH_RIGHT_VAR:    decode = dword_arith_right_variable;
      FN_LOGIC_RIGHT_FIXED:  decode = dword_logic_right_fixed;
      FN_LOGIC_RIGHT_PLUS32: decode = dword_logic_right_plus32;
      FN_LOGIC_RIGHT_VAR:    decode = dword_logic_right_variable;
      FN_SUB_TRAP:           decode = dword_subtract_trapping;
      FN_SUB_WRAP:           decode = dword_subtract_wrapping;
      default:               decode = op_none;
    endcase
  endfunction

  assign op = issue.valid ? decode(issue.funct) : op_none;

  // ****************************************************************
  // Shift count and fill
  // ****************************************************************
  always_comb begin
    count    = 6'h0;
    arith    = 1'b0;
    is_shift = 1'b1;
    case (op)
      dword_arith_right_fixed: begin
        count = {1'b0, issue.shift_amount_field};
        arith = 1'b1;
      end
      dword_arith_right_plus32: begin
        count = {1'b1, issue.shift_amount_field};
        arith = 1'b1;
      end
      dword_arith_right_variable: begin
        count = issue.first_source_register[SHAMT_W-1:0];
        arith = 1'b1;
      end
      dword_logic_right_fixed: count = {1'b0, issue.shift_amount_field};
      dword_logic_right_plus32: count = {1'b1, issue.shift_amount_field};
      dword_logic_right_variable: count = issue.first_source_register[SHAMT_W-1:0];
      default: is_shift = 1'b0;
    endcase
  end

  dword_right_shifter u_shift (
    .value  (issue.second_operand_register),
    .count  (count),
    .arith  (arith),
    .result (shifted)
  );

  // ****************************************************************
  // Subtract
  // ****************************************************************
  // signed overflow detect
  always_comb begin
    diff = issue.first_source_register - issue.second_operand_register;
    ovf  = (issue.first_source_register[SIGN_BIT] != issue.second_operand_register[SIGN_BIT])
         && (diff[SIGN_BIT] != issue.first_source_register[SIGN_BIT]);
  end

  always_comb begin
    wb_next  = '{wr_en: 1'b0, dest: issue.dest, data: DATA_RST};
    exc_next = 1'b0;
    if (is_shift) begin
      wb_next.wr_en = 1'b1;
      wb_next.data  = shifted;
    end else if (op == dword_subtract_trapping) begin
      wb_next.wr_en = !ovf;
      wb_next.data  = diff;
      exc_next      = ovf;
    end else if (op == dword_subtract_wrapping) begin
      wb_next.wr_en = 1'b1;
      wb_next.data  = diff;
    end
  end

  // ****************************************************************
  // Result stage
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_reg <= '{wr_en: 1'b0, dest: REG_RST, data: DATA_RST};
    end else begin
      wb_reg <= wb_next;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      exc_reg <= 1'b0;
    end else begin
      exc_reg <= exc_next;
    end
  end

  // Unknown functions are flagged, not silently dropped
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bad_reg <= 1'b0;
    end else begin
      bad_reg <= issue.valid && (op == op_none);
    end
  end

  assign wb           = wb_reg;
  assign overflow_exc = exc_reg;
  assign unknown_op   = bad_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Last cycle's operands, held only so the checks below can rebuild
  // the expected results without reusing the datapath above
  issue_t      chk_issue_reg;
  logic [63:0] chk_a;
  logic [63:0] chk_b;
  logic [4:0]  chk_amt;
  logic [64:0] chk_wide_diff;
  logic        chk_ovf;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chk_issue_reg <= '0;
    end else begin
      chk_issue_reg <= issue;
    end
  end

  // Overflow seen as a carry into a sign-extended 65-bit difference
  always_comb begin
    chk_a         = chk_issue_reg.first_source_register;
    chk_b         = chk_issue_reg.second_operand_register;
    chk_amt       = chk_issue_reg.shift_amount_field;
    chk_wide_diff = {chk_a[SIGN_BIT], chk_a} - {chk_b[SIGN_BIT], chk_b};
    chk_ovf       = chk_wide_diff[DATA_W] != chk_wide_diff[SIGN_BIT];
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Casts keep the sign shift self-determined beside unsigned wb.data
  sra_fixed_fill_a: assert property (
    (op == dword_arith_right_fixed) |=> wb.wr_en &&
      wb.data == 64'($signed(chk_b) >>> chk_amt))
    else $error("fixed arithmetic shift wrong");

  sra_plus32_fill_a: assert property (
    (op == dword_arith_right_plus32) |=> wb.wr_en &&
      wb.data == 64'($signed(chk_b) >>> (chk_amt + 7'h20)))
    else $error("plus32 arithmetic shift wrong");

  sra_var_fill_a: assert property (
    (op == dword_arith_right_variable) |=> wb.wr_en &&
      wb.data == 64'($signed(chk_b) >>> chk_a[SHAMT_W-1:0]))
    else $error("variable arithmetic shift wrong");

  var_low_bits_a: assert property (
    (op == dword_logic_right_variable) |=> wb.data == (chk_b >> chk_a[SHAMT_W-1:0]))
    else $error("variable count not six bits");

  srl_fixed_zero_a: assert property (
    (op == dword_logic_right_fixed) |=> wb.wr_en &&
      wb.data == (chk_b >> chk_amt))
    else $error("fixed logical shift wrong");

  srl_plus32_zero_a: assert property (
    (op == dword_logic_right_plus32) |=> wb.wr_en &&
      wb.data == (chk_b >> (chk_amt + 7'h20)))
    else $error("plus32 logical shift not zero filled");

  srl_var_write_a: assert property (
    (op == dword_logic_right_variable) |=> wb.wr_en && wb.dest == chk_issue_reg.dest)
    else $error("variable logical shift not written");

  sub_trap_ovf_a: assert property (
    (op == dword_subtract_trapping) |=> (overflow_exc == chk_ovf) &&
      (wb.wr_en == !chk_ovf) && (!wb.wr_en || wb.data == chk_wide_diff[SIGN_BIT:0]))
    else $error("trapping subtract wrong");

  sub_wrap_a: assert property (
    (op == dword_subtract_wrapping) |=> wb.wr_en && !overflow_exc &&
      wb.data == (chk_a - chk_b))
    else $error("wrapping subtract wrong");

  exc_only_trap_a: assert property (
    overflow_exc |-> $past(op) == dword_subtract_trapping)
    else $error("overflow raised by a non-trapping operation");

  decode_none_a: assert property (
    (issue.valid && op == op_none) |=> unknown_op && !wb.wr_en)
    else $error("unknown function wrote back");

  trap_seen_c: cover property (op == dword_subtract_trapping && ovf);
  shift63_c:   cover property (op == dword_arith_right_variable && count == 6'h3f);
  plus32_c:    cover property (op == dword_logic_right_plus32);
  wrap_ovf_c:  cover property (op == dword_subtract_wrapping && ovf);

endmodule
`default_nettype wire

// file: test/issue_source_model.sv
`default_nettype none
module issue_source_model (
  input  wire logic             ref_clk,
  output var  dword_alu_pkg::issue_t issue
);
  timeunit 1ns;
  timeprecision 100ps;
  import dword_alu_pkg::*;

  initial issue = '0;

  // ****************************************************************
  // Issue one operation per call
  // ****************************************************************
  // Returns just after the taking edge, so results can be judged at once
  // and the next call issues back to back in the following cycle.
  task automatic send(input logic [5:0] fn, input logic [4:0] amt, input logic [4:0] rd,
                      input logic [63:0] a, input logic [63:0] b);
    issue = {1'b1, fn, amt, rd, a, b};
    @(posedge ref_clk);
    #1;
  endtask

  // Released fields show the inverse, so stale operands never look live
  task automatic idle();
    issue = {1'b0, ~issue[$bits(issue_t)-2:0]};
  endtask
endmodule
`default_nettype wire

// file: test/doubleword_shift_subtract_alu_test.sv
`default_nettype none
module doubleword_shift_subtract_alu_test;
  timeunit 1ns;
  timeprecision 100ps;
  import dword_alu_pkg::*;

  logic   ref_clk;
  logic   arst_n;
  issue_t issue;
  wb_t    wb;
  logic   unknown_op;
  logic   overflow_exc;
  int     n_fail;
  int     n_tests;
  localparam logic [63:0] NEG = 64'hf0e1_d2c3_b4a5_9687;
  localparam logic [63:0] POS = 64'h7f6e_5d4c_3b2a_1908;

  issue_source_model u_issue_source_model (.ref_clk(ref_clk), .issue(issue));
  doubleword_shift_subtract_alu u_doubleword_shift_subtract_alu (
    .ref_clk(ref_clk), .arst_n(arst_n), .issue(issue), .wb(wb),
    .unknown_op(unknown_op), .overflow_exc(overflow_exc));

  // ****************************************************************
  // Comparisons
  // ****************************************************************
  task automatic cmp64(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Data is only meaningful when the write is enabled
  task automatic judge(input logic wr, input logic [63:0] d, input logic exc, input logic unk,
                       input logic [4:0] rd);
    cmp1("wr_en", wr, wb.wr_en);
    if (wr === 1'b1) cmp64("data", d, wb.data);
    cmp64("dest", {59'h0, rd}, {59'h0, wb.dest});
    cmp1("overflow_exc", exc, overflow_exc);
    cmp1("unknown_op", unk, unknown_op);
  endtask

  task automatic shift_op(input logic [5:0] fn, input logic [4:0] amt, input logic [63:0] a,
                          input logic [63:0] b, input int cnt, input logic arith);
    logic [63:0] e;
    // Expected value from the language's own shifts, not from a fill mask
    e = b >> cnt;
    if (arith) e = $signed(b) >>> cnt;
    u_issue_source_model.send(fn, amt, 5'(cnt), a, b);
    judge(1'b1, e, 1'b0, 1'b0, 5'(cnt));
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic arith_fixed();
    shift_op(FN_ARITH_RIGHT_FIXED, 5'h00, ~64'h0, NEG, 0, 1'b1);
    shift_op(FN_ARITH_RIGHT_FIXED, 5'h1f, 64'h0, NEG, 31, 1'b1);
    shift_op(FN_ARITH_RIGHT_FIXED, 5'h1f, 64'h0, POS, 31, 1'b1);
  endtask

  task automatic arith_plus32();
    shift_op(FN_ARITH_RIGHT_PLUS32, 5'h00, 64'h0, NEG, 32, 1'b1);
    shift_op(FN_ARITH_RIGHT_PLUS32, 5'h1f, 64'h0, NEG, 63, 1'b1);
  endtask

  task automatic arith_var();
    shift_op(FN_ARITH_RIGHT_VAR, 5'h1f, 64'h3f, NEG, 63, 1'b1);
    shift_op(FN_ARITH_RIGHT_VAR, 5'h00, 64'hffff_ffff_ffff_ffc5, NEG, 5, 1'b1);
  endtask

  task automatic logic_fixed();
    shift_op(FN_LOGIC_RIGHT_FIXED, 5'h00, ~64'h0, NEG, 0, 1'b0);
    shift_op(FN_LOGIC_RIGHT_FIXED, 5'h1f, 64'h0, NEG, 31, 1'b0);
  endtask

  task automatic logic_plus32();
    shift_op(FN_LOGIC_RIGHT_PLUS32, 5'h00, 64'h0, NEG, 32, 1'b0);
    shift_op(FN_LOGIC_RIGHT_PLUS32, 5'h1f, 64'h0, NEG, 63, 1'b0);
  endtask

  task automatic logic_var();
    shift_op(FN_LOGIC_RIGHT_VAR, 5'h1f, 64'h0, NEG, 0, 1'b0);
    shift_op(FN_LOGIC_RIGHT_VAR, 5'h00, 64'h8000_0000_0000_0041, NEG, 1, 1'b0);
  endtask

  task automatic sub_trap();
    u_issue_source_model.send(FN_SUB_TRAP, 5'h0, 5'h09, 64'h8000_0000_0000_0000, 64'h1);
    judge(1'b0, 64'h0, 1'b1, 1'b0, 5'h09);
    u_issue_source_model.send(FN_SUB_TRAP, 5'h0, 5'h0a, 64'h7fff_ffff_ffff_ffff, ~64'h0);
    judge(1'b0, 64'h0, 1'b1, 1'b0, 5'h0a);
    u_issue_source_model.send(FN_SUB_TRAP, 5'h0, 5'h0b, 64'h5, 64'h7);
    judge(1'b1, 64'hffff_ffff_ffff_fffe, 1'b0, 1'b0, 5'h0b);
  endtask

  task automatic sub_wrap();
    u_issue_source_model.send(FN_SUB_WRAP, 5'h0, 5'h0c, 64'h8000_0000_0000_0000, 64'h1);
    judge(1'b1, 64'h7fff_ffff_ffff_ffff, 1'b0, 1'b0, 5'h0c);
    u_issue_source_model.send(FN_SUB_WRAP, 5'h0, 5'h0d, 64'h7fff_ffff_ffff_ffff, ~64'h0);
    judge(1'b1, 64'h8000_0000_0000_0000, 1'b0, 1'b0, 5'h0d);
  endtask

  task automatic bad_funct();
    u_issue_source_model.send(6'h00, 5'h3, 5'h0e, POS, NEG);
    judge(1'b0, 64'h0, 1'b0, 1'b1, 5'h0e);
    u_issue_source_model.idle();
    @(posedge ref_clk);
    #1;
    cmp1("wr_en", 1'b0, wb.wr_en);
    cmp1("unknown_op", 1'b0, unknown_op);
  endtask

  task automatic complete_run();
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    n_fail = 0;
    n_tests = 0;
    arst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    cmp1("wr_en", 1'b0, wb.wr_en);
    arst_n = 1'b1;
    arith_fixed();
    arith_plus32();
    arith_var();
    logic_fixed();
    logic_plus32();
    logic_var();
    sub_trap();
    sub_wrap();
    bad_funct();
    complete_run();
  end

  // Whole run is some twenty-two cycles; this limit only cuts a hang short
  initial begin
    repeat (400) @(posedge ref_clk);
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
